// [logic/tcc_pkg.sv]
// constants, types and carriers for the 16-bit capture/compare timer
// Function
// - counter is 16-bit, counts up on source ticks
// - run bit starts/stops counting; count readable
// - source select: f1, f8, f32, fast oscillator
// - mode bit: 0 capture, 1 output compare
// - capture copies counter on active edge
// - edge select: rising, falling, both; 11 reserved
// - trigger from pin or slow oscillator tick
// - capture irq timing: count source or direct; always direct when pin filter on
// - compare mode: pin event always raises irq
// - rewriting irq fields may raise spurious request
// - pin filter off or sampled at f1/f8/f32
// - clear counter on match one if selected
// - match zero acts on group zero waveform
// - match one acts on group one waveform
// - each of six outputs has own enable
// - per-group invert of the three outputs
// - compare one full range, resets to FFFF
// - register zero resets 0000, FFFF in compare
// - writes to register zero ignored in capture
// - stopping clears counter to zero
// - overflow irq and capture-pin irq on edges
// - separate irqs for match zero and one
// - compare values load at overflow/match or immediately
package tcc_pkg;
   localparam int unsigned ADR_W = 10;
   localparam int unsigned DAT_W = 32;
   localparam int unsigned CNT_W = 16;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_COUNTER = 8'h90;
   localparam logic [7:0] IDX_CTL0 = 8'h9A;
   localparam logic [7:0] IDX_CTL1 = 8'h9B;
   localparam logic [7:0] IDX_CC0 = 8'h9C;
   localparam logic [7:0] IDX_CMP1 = 8'h9E;
   localparam logic [7:0] IDX_WOUT = 8'hFF;
   // reset values
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [15:0] RST_CC0 = 16'h0000;
   localparam logic [15:0] RST_CC0_CMP = 16'hFFFF;
   localparam logic [15:0] RST_CMP1 = 16'hFFFF;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_WOUT = 8'h00;
   // control zero: b5 reserved, reads zero
   localparam logic [7:0] CTL0_MASK = 8'hDF;
   localparam logic [7:0] CTL0_IRQ_FIELDS = 8'hD8;
   localparam int unsigned B_RUN = 0;
   localparam int unsigned B_SRC = 1;
   localparam int unsigned B_EDGE = 3;
   localparam int unsigned B_IRQ_TIME = 6;
   localparam int unsigned B_TRIG = 7;
   // control one
   localparam int unsigned B_FLT = 0;
   localparam int unsigned B_CLR = 2;
   localparam int unsigned B_MODE = 3;
   localparam int unsigned B_ACT0 = 4;
   localparam int unsigned B_ACT1 = 6;
   // waveform output control
   localparam int unsigned B_EN0 = 0;
   localparam int unsigned B_EN1 = 3;
   localparam int unsigned B_INV0 = 6;
   localparam int unsigned B_INV1 = 7;
   // prescaler: last count of the divide-by-8 and divide-by-32 phases
   localparam int unsigned DIV_W = 5;
   localparam logic [2:0] F8_LAST = 3'h7;
   localparam logic [4:0] F32_LAST = 5'h1F;
   localparam int unsigned FILT_LEN = 3;
   typedef enum logic [1:0] {SRC_F1, SRC_F8, SRC_F32, SRC_FAST} tcc_src_e;
   typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_RSVD} tcc_edge_e;
   typedef enum logic [1:0] {FLT_OFF, FLT_F1, FLT_F8, FLT_F32} tcc_flt_e;
   typedef enum logic [1:0] {ACT_KEEP, ACT_TOGGLE, ACT_LOW, ACT_HIGH} tcc_act_e;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [DAT_W-1:0] dat;
   } tcc_wb_req_s;
   typedef struct packed {
      logic [2:0] sh;
      logic lvl;
   } tcc_sync_s;
   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [7:0] wout;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cc0_buf;
      logic [CNT_W-1:0] cc0_act;
      logic [CNT_W-1:0] cmp1_buf;
      logic [CNT_W-1:0] cmp1_act;
      logic [DIV_W-1:0] div;
      logic [1:0] fcnt;
      logic flt;
      logic pend;
      logic g0;
      logic g1;
      logic [2:0] o0;
      logic [2:0] o1;
      logic ack;
      logic [DAT_W-1:0] rdat;
      logic irq_cap;
      logic irq_ovf;
      logic irq_m0;
      logic irq_m1;
   } tcc_state_s;
endpackage : tcc_pkg

// [logic/tcc_sync.sv]
// three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ns
module tcc_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous pin
   input wire logic pin,
   // synchronised view
   output logic lvl,
   output logic rise,
   output logic fall
);
   tcc_pkg::tcc_sync_s s_r;
   tcc_pkg::tcc_sync_s s_nxt;
   logic agree;

   assign agree = (s_r.sh[1] == s_r.sh[2]);
   assign lvl = s_r.lvl;
   assign rise = agree & s_r.sh[2] & ~s_r.lvl;
   assign fall = agree & ~s_r.sh[2] & s_r.lvl;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sh = {s_r.sh[1:0], pin};
      if (agree) begin
         s_nxt.lvl = s_r.sh[2];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : tcc_sync

// [logic/tcc_timer.sv]
// 16-bit capture/compare timer with wishbone register slave
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
module tcc_timer #(
   parameter int unsigned FILT_LEN = tcc_pkg::FILT_LEN
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone slave
   input wire tcc_pkg::tcc_wb_req_s wb_req,
   output logic [tcc_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // pins and oscillator inputs
   input wire logic measurement_input,
   input wire logic fast_osc_clock,
   input wire logic slow_osc_tick,
   // waveform outputs
   output logic group0_out_a,
   output logic group0_out_b,
   output logic group0_out_c,
   output logic group1_out_a,
   output logic group1_out_b,
   output logic group1_out_c,
   // interrupt request pulses
   output logic capture_pin_interrupt,
   output logic overflow_irq,
   output logic match0_irq,
   output logic match1_irq
);
   tcc_pkg::tcc_state_s s_r;
   tcc_pkg::tcc_state_s s_nxt;

   logic meas_lvl;
   logic fast_rise;
   logic slow_rise;
   logic slow_fall;

   // combinational helpers
   logic t8;
   logic t32;
   logic tick;
   logic fen;
   logic pin_rise;
   logic pin_fall;
   logic trg_rise;
   logic trg_fall;
   logic ev;
   logic run;
   logic cmp_mode;
   logic m0;
   logic m1;
   logic ovf;
   logic wr;
   logic rd;
   logic [7:0] idx;
   logic [tcc_pkg::CNT_W-1:0] wd16;

   tcc_sync u_meas (
      .clk(clk),
      .rst_b(rst_b),
      .pin(measurement_input),
      .lvl(meas_lvl),
      .rise(),
      .fall()
   );

   tcc_sync u_fast (
      .clk(clk),
      .rst_b(rst_b),
      .pin(fast_osc_clock),
      .lvl(),
      .rise(fast_rise),
      .fall()
   );

   tcc_sync u_slow (
      .clk(clk),
      .rst_b(rst_b),
      .pin(slow_osc_tick),
      .lvl(),
      .rise(slow_rise),
      .fall(slow_fall)
   );

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction : merge16

   // waveform action on a compare match
   function automatic logic wave(input logic [1:0] act, input logic lvl);
      logic r;
      case (tcc_pkg::tcc_act_e'(act))
         tcc_pkg::ACT_KEEP: r = lvl;
         tcc_pkg::ACT_TOGGLE: r = ~lvl;
         tcc_pkg::ACT_LOW: r = 1'b0;
         tcc_pkg::ACT_HIGH: r = 1'b1;
         default: r = lvl;
      endcase
      return r;
   endfunction : wave

   assign wb_dat_o = s_r.rdat;
   assign wb_ack_o = s_r.ack;
   assign group0_out_a = s_r.o0[0];
   assign group0_out_b = s_r.o0[1];
   assign group0_out_c = s_r.o0[2];
   assign group1_out_a = s_r.o1[0];
   assign group1_out_b = s_r.o1[1];
   assign group1_out_c = s_r.o1[2];
   assign capture_pin_interrupt = s_r.irq_cap;
   assign overflow_irq = s_r.irq_ovf;
   assign match0_irq = s_r.irq_m0;
   assign match1_irq = s_r.irq_m1;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.irq_cap = 1'b0;
      s_nxt.irq_ovf = 1'b0;
      s_nxt.irq_m0 = 1'b0;
      s_nxt.irq_m1 = 1'b0;
      run = s_r.ctl0[tcc_pkg::B_RUN];
      cmp_mode = s_r.ctl1[tcc_pkg::B_MODE];
      idx = wb_req.adr[tcc_pkg::ADR_W-1:2];
      wr = wb_req.cyc & wb_req.stb & wb_req.we & ~s_r.ack;
      rd = wb_req.cyc & wb_req.stb & ~wb_req.we & ~s_r.ack;
      wd16 = '0;
      m0 = 1'b0;
      m1 = 1'b0;
      ovf = 1'b0;

      // prescaler enables
      s_nxt.div = s_r.div + {{(tcc_pkg::DIV_W-1){1'b0}}, 1'b1};
      t8 = (s_r.div[2:0] == tcc_pkg::F8_LAST);
      t32 = (s_r.div == tcc_pkg::F32_LAST);
      case (tcc_pkg::tcc_src_e'(s_r.ctl0[tcc_pkg::B_SRC +: 2]))
         tcc_pkg::SRC_F1: tick = 1'b1;
         tcc_pkg::SRC_F8: tick = t8;
         tcc_pkg::SRC_F32: tick = t32;
         tcc_pkg::SRC_FAST: tick = fast_rise;
         default: tick = 1'b0;
      endcase

      // measurement pin digital filter
      case (tcc_pkg::tcc_flt_e'(s_r.ctl1[tcc_pkg::B_FLT +: 2]))
         tcc_pkg::FLT_F1: fen = 1'b1;
         tcc_pkg::FLT_F8: fen = t8;
         tcc_pkg::FLT_F32: fen = t32;
         default: fen = 1'b0;
      endcase
      if (s_r.ctl1[tcc_pkg::B_FLT +: 2] == 2'h0) begin
         s_nxt.flt = meas_lvl;
         s_nxt.fcnt = 2'h0;
      end else if (fen) begin
         if (meas_lvl == s_r.flt) begin
            s_nxt.fcnt = 2'h0;
         end else if (s_r.fcnt == 2'(FILT_LEN - 1)) begin
            // level held for the whole run of samples
            s_nxt.flt = meas_lvl;
            s_nxt.fcnt = 2'h0;
         end else begin
            s_nxt.fcnt = s_r.fcnt + 2'h1;
         end
      end
      pin_rise = s_nxt.flt & ~s_r.flt;
      pin_fall = ~s_nxt.flt & s_r.flt;

      // trigger source and active edge
      if (s_r.ctl0[tcc_pkg::B_TRIG]) begin
         trg_rise = slow_rise;
         trg_fall = slow_fall;
      end else begin
         trg_rise = pin_rise;
         trg_fall = pin_fall;
      end
      case (tcc_pkg::tcc_edge_e'(s_r.ctl0[tcc_pkg::B_EDGE +: 2]))
         tcc_pkg::EDGE_RISE: ev = trg_rise;
         tcc_pkg::EDGE_FALL: ev = trg_fall;
         tcc_pkg::EDGE_BOTH: ev = trg_rise | trg_fall;
         default: ev = 1'b0;
      endcase

      // capture-pin interrupt timing
      if (cmp_mode) begin
         s_nxt.irq_cap = ev;
         s_nxt.pend = 1'b0;
      end else if (s_r.ctl0[tcc_pkg::B_IRQ_TIME] || s_r.ctl1[tcc_pkg::B_FLT +: 2] != 2'h0) begin
         s_nxt.irq_cap = ev;
         s_nxt.pend = 1'b0;
      end else if (tick) begin
         // held edge released on the count source, new edge included
         s_nxt.irq_cap = s_r.pend | ev;
         s_nxt.pend = 1'b0;
      end else begin
         s_nxt.pend = s_r.pend | ev;
      end

      // capture into register zero
      if (!cmp_mode && run && ev) begin
         s_nxt.cc0_buf = s_r.cnt;
         s_nxt.cc0_act = s_r.cnt;
      end

      // counter
      if (!run) begin
         s_nxt.cnt = tcc_pkg::RST_CNT;
      end else if (tick) begin
         m0 = cmp_mode & (s_r.cnt == s_r.cc0_act);
         m1 = cmp_mode & (s_r.cnt == s_r.cmp1_act);
         if (m1 && s_r.ctl1[tcc_pkg::B_CLR]) begin
            s_nxt.cnt = tcc_pkg::RST_CNT;
         end else begin
            ovf = (s_r.cnt == tcc_pkg::CNT_MAX);
            s_nxt.cnt = s_r.cnt + 16'h0001;
         end
      end
      s_nxt.irq_ovf = ovf;
      s_nxt.irq_m0 = m0;
      s_nxt.irq_m1 = m1;

      // waveform groups
      if (m0) begin
         s_nxt.g0 = wave(s_r.ctl1[tcc_pkg::B_ACT0 +: 2], s_r.g0);
      end
      if (m1) begin
         s_nxt.g1 = wave(s_r.ctl1[tcc_pkg::B_ACT1 +: 2], s_r.g1);
      end

      // buffered compare values move to the active set
      if (cmp_mode && (s_r.ctl1[tcc_pkg::B_CLR] ? m1 : ovf)) begin
         s_nxt.cc0_act = s_r.cc0_buf;
         s_nxt.cmp1_act = s_r.cmp1_buf;
      end

      // register writes
      if (wr) begin
         case (idx)
            tcc_pkg::IDX_CTL0: begin
               if (wb_req.sel[0]) begin
                  s_nxt.ctl0 = wb_req.dat[7:0] & tcc_pkg::CTL0_MASK;
                  if (((s_nxt.ctl0 ^ s_r.ctl0) & tcc_pkg::CTL0_IRQ_FIELDS) != 8'h00) begin
                     s_nxt.irq_cap = 1'b1;
                  end
               end
            end
            tcc_pkg::IDX_CTL1: begin
               if (wb_req.sel[0]) begin
                  s_nxt.ctl1 = wb_req.dat[7:0];
                  if (wb_req.dat[tcc_pkg::B_MODE] && !cmp_mode) begin
                     s_nxt.cc0_buf = tcc_pkg::RST_CC0_CMP;
                     s_nxt.cc0_act = tcc_pkg::RST_CC0_CMP;
                  end
               end
            end
            tcc_pkg::IDX_CC0: begin
               if (cmp_mode) begin
                  s_nxt.cc0_buf = merge16(s_r.cc0_buf, wb_req.dat, wb_req.sel);
               end
            end
            tcc_pkg::IDX_CMP1: begin
               s_nxt.cmp1_buf = merge16(s_r.cmp1_buf, wb_req.dat, wb_req.sel);
            end
            tcc_pkg::IDX_WOUT: begin
               if (wb_req.sel[0]) begin
                  s_nxt.wout = wb_req.dat[7:0];
               end
            end
            default: begin
               wd16 = '0;
            end
         endcase
      end

      // stopped: written values take effect at once
      if (!run && cmp_mode) begin
         s_nxt.cc0_act = s_nxt.cc0_buf;
         s_nxt.cmp1_act = s_nxt.cmp1_buf;
      end else if (!run) begin
         s_nxt.cmp1_act = s_nxt.cmp1_buf;
      end

      // register reads, answered with ack
      if (rd) begin
         case (idx)
            tcc_pkg::IDX_COUNTER: wd16 = s_r.cnt;
            tcc_pkg::IDX_CTL0: wd16 = {8'h00, s_r.ctl0};
            tcc_pkg::IDX_CTL1: wd16 = {8'h00, s_r.ctl1};
            tcc_pkg::IDX_CC0: wd16 = s_r.cc0_buf;
            tcc_pkg::IDX_CMP1: wd16 = s_r.cmp1_buf;
            tcc_pkg::IDX_WOUT: wd16 = {8'h00, s_r.wout};
            default: wd16 = '0;
         endcase
         s_nxt.rdat = {16'h0000, wd16};
      end
      s_nxt.ack = wr | rd;

      // enabled, optionally inverted waveform pins
      for (int i = 0; i < 3; i++) begin
         s_nxt.o0[i] = s_nxt.wout[tcc_pkg::B_EN0 + i] & (s_nxt.g0 ^ s_nxt.wout[tcc_pkg::B_INV0]);
         s_nxt.o1[i] = s_nxt.wout[tcc_pkg::B_EN1 + i] & (s_nxt.g1 ^ s_nxt.wout[tcc_pkg::B_INV1]);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
         s_r.ctl0 <= tcc_pkg::RST_CTL;
         s_r.ctl1 <= tcc_pkg::RST_CTL;
         s_r.wout <= tcc_pkg::RST_WOUT;
         s_r.cnt <= tcc_pkg::RST_CNT;
         s_r.cc0_buf <= tcc_pkg::RST_CC0;
         s_r.cc0_act <= tcc_pkg::RST_CC0;
         s_r.cmp1_buf <= tcc_pkg::RST_CMP1;
         s_r.cmp1_act <= tcc_pkg::RST_CMP1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : tcc_timer

// [test/tcc_timer_chk.sv]
// assertions on the timer's bus, waveform and event ports
`timescale 1ns/1ns
module tcc_timer_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register bus
   input wire tcc_pkg::tcc_wb_req_s wb_req,
   input wire logic [tcc_pkg::DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   // pins and events
   input wire logic group0_out_a,
   input wire logic group1_out_c,
   input wire logic overflow_irq,
   input wire logic match0_irq,
   input wire logic match1_irq
);
   logic tk;
   logic [7:0] idx;
   logic [7:0] c0_r, c1_r, wo_r;
   logic rd_cnt_r;
   assign tk = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign idx = wb_req.adr[9:2];
   // shadows of what software wrote
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         c0_r <= 8'h00;
         c1_r <= 8'h00;
         wo_r <= 8'h00;
         rd_cnt_r <= 1'b0;
      end else begin
         rd_cnt_r <= tk && !wb_req.we && idx == tcc_pkg::IDX_COUNTER;
         if (tk && wb_req.we && wb_req.sel[0]) begin
            if (idx == tcc_pkg::IDX_CTL0) c0_r <= wb_req.dat[7:0];
            if (idx == tcc_pkg::IDX_CTL1) c1_r <= wb_req.dat[7:0];
            if (idx == tcc_pkg::IDX_WOUT) wo_r <= wb_req.dat[7:0];
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ack_follows_req: assert property (tk |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_hi_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("read data above bit 15 not zero");
   a_stop_reads_zero: assert property ((wb_ack_o && rd_cnt_r && !c0_r[0] && !$past(c0_r[0], 2))
      |-> wb_dat_o == 32'h0000_0000)
      else $error("stopped counter not zero");
   a_match_in_compare: assert property ((match0_irq || match1_irq)
      |-> $past(c1_r[3]) && $past(c0_r[0]))
      else $error("match event outside running compare mode");
   a_ovf_needs_run: assert property (overflow_irq |-> $past(c0_r[0]))
      else $error("overflow while stopped");
   a_ovf_pulse: assert property (overflow_irq |=> !overflow_irq)
      else $error("overflow event longer than one cycle");
   a_g0_disabled_low: assert property ((!wo_r[0] && !$past(wo_r[0])) |-> !group0_out_a)
      else $error("disabled group zero pin driven");
   a_g1_disabled_low: assert property ((!wo_r[5] && !$past(wo_r[5])) |-> !group1_out_c)
      else $error("disabled group one pin driven");
   cover property (overflow_irq);
   cover property (match1_irq ##1 !match1_irq);
   cover property (group0_out_a && group1_out_c);
endmodule : tcc_timer_chk

// [test/tcc_pin_model.sv]
// measurement pin, slow tick and fast oscillator source
`timescale 1ns/1ns
module tcc_pin_model (
   // control from the bench
   input wire logic clk,
   input wire logic go,
   input wire logic slow,
   input wire logic [7:0] len,
   // pins
   output logic measurement_input,
   output logic slow_osc_tick,
   output logic fast_osc_clock
);
   logic [7:0] n;
   logic s;
   initial begin
      n = 8'h00;
      s = 1'b0;
      fast_osc_clock = 1'b0;
      #3;
      forever #24 fast_osc_clock = ~fast_osc_clock;
   end
   // one high pulse of len clocks on the chosen line, low when idle
   always @(posedge clk) begin
      if (go) begin
         n <= len;
         s <= slow;
      end else if (n != 8'h00) begin
         n <= n - 8'h01;
      end
   end
   assign measurement_input = n != 8'h00 && !s;
   assign slow_osc_tick = n != 8'h00 && s;
endmodule : tcc_pin_model

// [test/test_tcc_timer.sv]
// bench for the capture/compare timer
`timescale 1ns/1ns
module test_tcc_timer;
   logic clk, rst_b, go, slow, mi, st, fo, ack, cap, ovf, m0, m1;
   logic [7:0] len;
   logic [5:0] outs;
   logic [2:0] ev;
   logic [31:0] rd, q, prv;
   tcc_pkg::tcc_wb_req_s req;
   int error_cnt, comparisons, ncap, p;
   logic [7:0] ri[7] = '{8'h90, 8'h9A, 8'h9B, 8'h9C, 8'h9E, 8'hFF, 8'h80};
   logic [15:0] rv[7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h0};
   int ps[4] = '{1, 8, 32, 6};
   logic [1:0] ac[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
   logic av[4] = '{1'h1, 1'h0, 1'h1, 1'h1};
   logic [7:0] wo[4] = '{8'h3F, 8'hFF, 8'h89, 8'h00};
   logic [5:0] ov[4] = '{6'h3F, 6'h00, 6'h20, 6'h00};
   assign ev = {ovf, m1, m0};
   tcc_timer #(.FILT_LEN(3)) u_dut (.clk(clk), .rst_b(rst_b), .wb_req(req), .wb_dat_o(rd), .wb_ack_o(ack),
      .measurement_input(mi), .fast_osc_clock(fo), .slow_osc_tick(st), .group0_out_a(outs[5]),
      .group0_out_b(outs[4]), .group0_out_c(outs[3]), .group1_out_a(outs[2]), .group1_out_b(outs[1]),
      .group1_out_c(outs[0]), .capture_pin_interrupt(cap), .overflow_irq(ovf), .match0_irq(m0),
      .match1_irq(m1));
   tcc_pin_model u_pin (.clk(clk), .go(go), .slow(slow), .len(len), .measurement_input(mi),
      .slow_osc_tick(st), .fast_osc_clock(fo));
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] i, input logic [15:0] d);
      req <= '{1'b1, 1'b1, w, {i, 2'h0}, 4'hF, {16'h0000, d}};
      do @(posedge clk); while (ack !== 1'b1);
      q = rd;
      req <= '0;
      @(posedge clk);
   endtask : wb
   task wt(input int k);
      p = 0;
      do begin
         @(posedge clk);
         p++;
      end while (ev[k] !== 1'b1);
   endtask : wt
   task cap_run(input logic [7:0] c0, input logic [7:0] c1, input logic s, input logic [7:0] l, input int e);
      wb(1'b1, 8'h9A, 16'h0000);
      // preset register zero so that any capture changes it
      wb(1'b1, 8'h9B, 16'h0008);
      wb(1'b1, 8'h9C, 16'hFFFF);
      wb(1'b1, 8'h9B, {8'h00, c1});
      wb(1'b1, 8'h9A, {8'h00, c0 & 8'hFE});
      wb(1'b1, 8'h9A, {8'h00, c0});
      wb(1'b0, 8'h9C, 16'h0000);
      prv = q;
      chk("cc0_pre", 32'h0000FFFF, prv);
      repeat (4) @(posedge clk);
      ncap = 0;
      go <= 1'b1;
      slow <= s;
      len <= l;
      @(posedge clk);
      go <= 1'b0;
      repeat (32'(l) + 12) @(posedge clk);
      chk("cap_cnt", e, ncap);
      wb(1'b0, 8'h9C, 16'h0000);
      if (!c1[3]) chk("cap_val", 32'(e != 0), 32'(q != prv));
   endtask : cap_run
   task test_done;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   always @(posedge clk) if (cap === 1'b1) ncap++;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #800000;
      error_cnt++;
      test_done;
   end
   initial begin
      rst_b = 1'b0;
      go = 1'b0;
      slow = 1'b0;
      len = 8'h00;
      req = '0;
      error_cnt = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      foreach (ri[i]) begin
         wb(1'b0, ri[i], 16'h0000);
         chk("reset", {16'h0000, rv[i]}, q);
      end
      wb(1'b1, 8'h90, 16'h1234);
      wb(1'b0, 8'h90, 16'h0000);
      chk("cnt_ro", 0, q);
      wb(1'b1, 8'h9C, 16'h1234);
      wb(1'b0, 8'h9C, 16'h0000);
      chk("cc0_cap", 0, q);
      wb(1'b1, 8'h9B, 16'h000C);
      wb(1'b0, 8'h9C, 16'h0000);
      chk("cc0_cmp", 32'h0000FFFF, q);
      wb(1'b1, 8'h9E, 16'h0003);
      for (int s = 0; s < 4; s++) begin
         wb(1'b1, 8'h9A, 16'h0000);
         wb(1'b1, 8'h9A, 16'(s * 2));
         wb(1'b1, 8'h9A, 16'(s * 2 + 1));
         wt(1);
         wt(1);
         chk("period", 4 * ps[s], p);
      end
      wb(1'b1, 8'h9A, 16'h0000);
      wb(1'b0, 8'h90, 16'h0000);
      chk("cnt_stop", 0, q);
      wb(1'b1, 8'h9E, 16'h0030);
      wb(1'b1, 8'h9C, 16'h0018);
      wb(1'b0, 8'h9E, 16'h0000);
      chk("cmp1", 32'h00000030, q);
      wb(1'b1, 8'hFF, 16'h003F);
      wb(1'b1, 8'h9A, 16'h0001);
      foreach (ac[i]) begin
         wt(1);
         wb(1'b1, 8'h9B, {8'h00, 2'h3, ac[i], 4'hC});
         wt(0);
         repeat (3) @(posedge clk);
         chk("g0_act", 32'(av[i]), 32'(outs[5]));
      end
      foreach (wo[i]) begin
         wb(1'b1, 8'hFF, {8'h00, wo[i]});
         repeat (2) @(posedge clk);
         chk("outs", 32'(ov[i]), 32'(outs));
      end
      // new compare one value waits for the next match one
      wt(1);
      wb(1'b1, 8'h9E, 16'h0010);
      wt(1);
      chk("cmp_hold", 46, p);
      wt(1);
      chk("cmp_load", 17, p);
      wb(1'b1, 8'h9A, 16'h0000);
      wb(1'b1, 8'h9B, 16'h0008);
      wb(1'b1, 8'h9A, 16'h0001);
      wt(2);
      chk("ovf", 1, 32'(p > 65525 && p < 65540));
      wb(1'b1, 8'h9A, 16'h0000);
      ncap = 0;
      wb(1'b1, 8'h9A, 16'h0008);
      chk("spurious", 1, ncap);
      cap_run(8'h41, 8'h00, 1'b0, 8'd20, 1);
      cap_run(8'h49, 8'h00, 1'b0, 8'd20, 1);
      cap_run(8'h51, 8'h00, 1'b0, 8'd20, 2);
      cap_run(8'h59, 8'h00, 1'b0, 8'd20, 0);
      cap_run(8'hC1, 8'h00, 1'b0, 8'd20, 0);
      cap_run(8'hC1, 8'h00, 1'b1, 8'd20, 1);
      cap_run(8'h41, 8'h01, 1'b0, 8'd2, 0);
      cap_run(8'h41, 8'h01, 1'b0, 8'd20, 1);
      cap_run(8'h41, 8'h00, 1'b0, 8'd2, 1);
      cap_run(8'h03, 8'h00, 1'b0, 8'd20, 1);
      cap_run(8'h01, 8'h08, 1'b0, 8'd20, 1);
      test_done;
   end
endmodule : test_tcc_timer
bind tcc_timer tcc_timer_chk u_chk (.clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .group0_out_a(group0_out_a), .group1_out_c(group1_out_c),
   .overflow_irq(overflow_irq), .match0_irq(match0_irq), .match1_irq(match1_irq));
